// *** hdl/iag_pkg.sv ***
// Package: constants and types for the integer address generator
package iag_pkg;
  localparam int DATA_W   = 32;
  localparam int REG_CNT  = 31;
  localparam int REG_AW   = 5;
  localparam int UNIT_CNT = 2;
  localparam int CB_CNT   = 4;
  localparam int CB_AW    = 2;
  localparam int STAT_W   = 4;
  localparam int STAT_Z   = 0;
  localparam int STAT_N   = 1;
  localparam int STAT_C   = 2;
  localparam int STAT_V   = 3;

  localparam logic [DATA_W-1:0] REG_RST  = 32'h0000_0000;
  localparam logic [STAT_W-1:0] STAT_RST = 4'h0;

  typedef enum logic [9:0] {
    OP_ADD   = 10'h001,
    OP_SUB   = 10'h002,
    OP_AND   = 10'h004,
    OP_OR    = 10'h008,
    OP_XOR   = 10'h010,
    OP_MOV   = 10'h020,
    OP_LOOP  = 10'h040,
    OP_CBSET = 10'h080,
    OP_LDST  = 10'h100,
    OP_LOAD  = 10'h200
  } iag_op_type;

  typedef enum logic [2:0] {
    AM_IMM  = 3'h1,
    AM_PRE  = 3'h2,
    AM_POST = 3'h4
  } iag_amode_type;

  typedef enum logic [2:0] {
    SZ_ONE  = 3'h1,
    SZ_TWO  = 3'h2,
    SZ_FOUR = 3'h4
  } iag_size_type;
endpackage : iag_pkg

// *** hdl/iag_dp_if.sv ***
// Interface: operands and results between a unit and its datapath helpers
`timescale 1ns/1ps
interface iag_dp_if;
  import iag_pkg::*;
  logic [DATA_W-1:0] a_val;
  logic [DATA_W-1:0] b_val;
  logic [DATA_W-1:0] base;
  logic [DATA_W-1:0] len;
  logic              circ;
  logic              brev;
  iag_op_type        op;
  logic [DATA_W-1:0] next_ptr;
  logic [DATA_W-1:0] res;
  logic [STAT_W-1:0] flags;

  modport core_mp (output a_val, b_val, base, len, circ, brev, op, input next_ptr, res, flags);
  modport addr_mp (input a_val, b_val, base, len, circ, brev, output next_ptr);
  modport alu_mp  (input a_val, b_val, op, output res, flags);
endinterface : iag_dp_if

// *** hdl/iag_addr_calc.sv ***
// Next-pointer calculation: linear, circular wrap and bit-reversed carry
`timescale 1ns/1ps
module iag_addr_calc (
  iag_dp_if.addr_mp dp  // Pointer, modifier and buffer in, next pointer out
);
  import iag_pkg::*;

  logic [DATA_W-1:0] sum;
  logic [DATA_W-1:0] lim;

  function automatic logic [DATA_W-1:0] bit_rev(input logic [DATA_W-1:0] v);
    bit_rev = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      bit_rev[i] = v[DATA_W-1-i];
    end
  endfunction : bit_rev

  // Wrap is a compare against base and base plus length, so any base works
  always_comb
  begin
    sum = dp.a_val + dp.b_val;
    lim = dp.base + dp.len;
    if (dp.brev)
      dp.next_ptr = bit_rev(bit_rev(dp.a_val) + bit_rev(dp.b_val));
    else if (dp.circ && sum >= lim)
      dp.next_ptr = sum - dp.len;
    else if (dp.circ && sum < dp.base)
      dp.next_ptr = sum + dp.len;
    else
      dp.next_ptr = sum;
  end
endmodule : iag_addr_calc

// *** hdl/iag_int_alu.sv ***
// Integer arithmetic and logic with status flags
`timescale 1ns/1ps
module iag_int_alu (
  iag_dp_if.alu_mp dp  // Operands and opcode in, result and flags out
);
  import iag_pkg::*;

  logic [DATA_W:0] wide;
  logic            ovf;

  always_comb
  begin
    wide = '0;
    ovf  = 1'b0;
    case (dp.op)
      OP_ADD:
      begin
        wide = {1'b0, dp.a_val} + {1'b0, dp.b_val};
        ovf  = (dp.a_val[DATA_W-1] == dp.b_val[DATA_W-1]) && (wide[DATA_W-1] != dp.a_val[DATA_W-1]);
      end
      OP_SUB:
      begin
        wide = {1'b0, dp.a_val} - {1'b0, dp.b_val};
        ovf  = (dp.a_val[DATA_W-1] != dp.b_val[DATA_W-1]) && (wide[DATA_W-1] != dp.a_val[DATA_W-1]);
      end
      OP_AND:  wide = {1'b0, dp.a_val & dp.b_val};
      OP_OR:   wide = {1'b0, dp.a_val | dp.b_val};
      OP_XOR:  wide = {1'b0, dp.a_val ^ dp.b_val};
      OP_MOV:  wide = {1'b0, dp.b_val};
      OP_LOOP: wide = {1'b0, dp.a_val} - (DATA_W+1)'(1);
      default: wide = {1'b0, dp.a_val};
    endcase
    dp.res = wide[DATA_W-1:0];
  end

  always_comb
  begin
    dp.flags         = '0;
    dp.flags[STAT_Z] = (wide[DATA_W-1:0] == '0);
    dp.flags[STAT_N] = wide[DATA_W-1];
    dp.flags[STAT_C] = wide[DATA_W];
    dp.flags[STAT_V] = ovf;
  end
endmodule : iag_int_alu

// *** hdl/iag_top.sv ***
// Dual integer address units: register files, address issue, integer pipe, load interlock
// Function
// - Each of two units owns a 31-word register file.
// - Address generation and pointer write-back happen in the same access.
// - Immediate, pre-modify and post-modify indirect addressing are supported.
// - Modulus and bit-reverse math imposes no placement restriction on buffers.
// - Every access carries a one, two or four word size.
// - Each unit holds four circular buffer register sets, eight total.
// - Pointer crossing a buffer boundary wraps back in hardware.
// - Buffer start and end may sit at any address.
// - Units also run integer arithmetic and logic on their register file.
// - Integer pipe is one stage; results usable next cycle.
// - Dependency check stalls issue when a needed result is not ready.
// - Bit-reversed addressing and zero-overhead loop counting are supported.
// - Each unit keeps its own status flags.
`timescale 1ns/1ps
module iag_top (
  input  wire logic                                  core_clk_in,     // Core clock
  input  wire logic                                  rst_in,          // Async reset, active high
  input  wire logic                                  iss_valid_in,    // Instruction offered
  input  wire logic                                  iss_unit_in,     // Target unit
  input  wire iag_pkg::iag_op_type                   iss_op_in,       // Operation
  input  wire iag_pkg::iag_amode_type                iss_amode_in,    // Addressing mode
  input  wire iag_pkg::iag_size_type                 iss_size_in,     // Access size
  input  wire logic                                  iss_circ_in,     // Circular update
  input  wire logic                                  iss_brev_in,     // Bit-reversed update
  input  wire logic [iag_pkg::CB_AW-1:0]             iss_cb_in,       // Circular buffer select
  input  wire logic [iag_pkg::REG_AW-1:0]            iss_dst_in,      // Destination register
  input  wire logic [iag_pkg::REG_AW-1:0]            iss_src_a_in,    // Pointer or operand A
  input  wire logic [iag_pkg::REG_AW-1:0]            iss_src_b_in,    // Modifier or operand B
  input  wire logic                                  iss_use_imm_in,  // B from immediate
  input  wire logic [iag_pkg::DATA_W-1:0]            iss_imm_in,      // Immediate value
  output logic                                       iss_stall_out,   // Issue held this cycle
  output logic                                       mem_req_out,     // Access request pulse
  output logic                                       mem_unit_out,    // Requesting unit
  output logic                                       mem_load_out,    // Access is a load
  output logic [iag_pkg::DATA_W-1:0]                 mem_addr_out,    // Access address
  output iag_pkg::iag_size_type                      mem_size_out,    // Access size
  input  wire logic                                  mem_rd_valid_in, // Load data returned
  input  wire logic [iag_pkg::DATA_W-1:0]            mem_rd_data_in,  // Load data
  output logic [iag_pkg::UNIT_CNT*iag_pkg::STAT_W-1:0] stat_out,      // Status of all units
  output logic                                       loop_taken_out   // Loop count not yet zero
);
  import iag_pkg::*;

  logic [DATA_W-1:0] rf_r      [UNIT_CNT][REG_CNT];
  logic [DATA_W-1:0] cb_base_r [UNIT_CNT][CB_CNT];
  logic [DATA_W-1:0] cb_len_r  [UNIT_CNT][CB_CNT];
  logic [STAT_W-1:0] stat_r    [UNIT_CNT];
  logic [DATA_W-1:0] a_w       [UNIT_CNT];
  logic [DATA_W-1:0] b_w       [UNIT_CNT];
  logic [DATA_W-1:0] next_w    [UNIT_CNT];
  logic [DATA_W-1:0] res_w     [UNIT_CNT];
  logic [STAT_W-1:0] flags_w   [UNIT_CNT];
  logic              ld_pend_r;
  logic              ld_unit_r;
  logic [REG_AW-1:0] ld_dst_r;
  logic              mem_req_r;
  logic              mem_unit_r;
  logic              mem_load_r;
  logic [DATA_W-1:0] mem_addr_r;
  iag_size_type      mem_size_r;
  logic              loop_taken_r;
  logic              acc_w;
  logic              is_mem_w;
  logic              is_alu_w;
  logic              dep_hit_w;
  logic              wr_en_w;
  logic [REG_AW-1:0] wr_idx_w;
  logic [DATA_W-1:0] wr_val_w;
  logic [DATA_W-1:0] cur_a_w;
  logic [DATA_W-1:0] cur_b_w;
  logic [DATA_W-1:0] cur_next_w;
  logic [DATA_W-1:0] cur_res_w;
  logic [DATA_W-1:0] addr_w;
  logic              chk_en_r;
  logic              chk_u_r;
  logic [REG_AW-1:0] chk_d_r;
  logic [DATA_W-1:0] chk_v_r;

  // Index 31 has no storage and reads as zero
  function automatic logic [DATA_W-1:0] rf_rd(input logic u, input logic [REG_AW-1:0] idx);
    rf_rd = (idx < REG_AW'(REG_CNT)) ? rf_r[u][idx] : '0;
  endfunction : rf_rd

  function automatic logic reg_ok(input logic [REG_AW-1:0] idx);
    reg_ok = (idx < REG_AW'(REG_CNT));
  endfunction : reg_ok

  for (genvar u = 0; u < UNIT_CNT; u++)
  begin : g_unit
    iag_dp_if dp ();
    // Process form, so a register write also refreshes the reads inside the function
    always_comb
    begin
      dp.a_val = rf_rd(1'(u), iss_src_a_in);
      dp.b_val = iss_use_imm_in ? iss_imm_in : rf_rd(1'(u), iss_src_b_in);
    end
    assign dp.base    = cb_base_r[u][iss_cb_in];
    assign dp.len     = cb_len_r[u][iss_cb_in];
    assign dp.circ    = iss_circ_in;
    assign dp.brev    = iss_brev_in;
    assign dp.op      = iss_op_in;
    assign a_w[u]     = dp.a_val;
    assign b_w[u]     = dp.b_val;
    assign next_w[u]  = dp.next_ptr;
    assign res_w[u]   = dp.res;
    assign flags_w[u] = dp.flags;
    assign stat_out[u*STAT_W +: STAT_W] = stat_r[u];

    iag_addr_calc u_addr (
      .dp (dp.addr_mp)
    );
    iag_int_alu u_alu (
      .dp (dp.alu_mp)
    );
  end

  assign cur_a_w    = a_w[iss_unit_in];
  assign cur_b_w    = b_w[iss_unit_in];
  assign cur_next_w = next_w[iss_unit_in];
  assign cur_res_w  = res_w[iss_unit_in];
  assign is_mem_w   = (iss_op_in == OP_LDST) || (iss_op_in == OP_LOAD);
  assign is_alu_w   = !is_mem_w && (iss_op_in != OP_CBSET);

  // Only loads are multi-cycle; the single write port is also held while a load returns
  assign dep_hit_w = ld_pend_r && (ld_unit_r == iss_unit_in) &&
                     ((ld_dst_r == iss_src_a_in) || (!iss_use_imm_in && ld_dst_r == iss_src_b_in) ||
                      (ld_dst_r == iss_dst_in));
  assign iss_stall_out = iss_valid_in &&
                         (mem_rd_valid_in || dep_hit_w || (ld_pend_r && iss_op_in == OP_LOAD));
  assign acc_w = iss_valid_in && !iss_stall_out;

  always_comb
  begin
    case (iss_amode_in)
      AM_IMM:  addr_w = iss_imm_in;
      AM_PRE:  addr_w = cur_next_w;
      AM_POST: addr_w = cur_a_w;
      default: addr_w = cur_a_w;
    endcase
  end

  always_comb
  begin
    wr_en_w  = 1'b0;
    wr_idx_w = iss_dst_in;
    wr_val_w = cur_res_w;
    if (acc_w && is_mem_w && iss_amode_in != AM_IMM)
    begin
      wr_en_w  = reg_ok(iss_src_a_in);
      wr_idx_w = iss_src_a_in;
      wr_val_w = cur_next_w;
    end
    else if (acc_w && is_alu_w)
      wr_en_w = reg_ok(iss_dst_in);
  end

  // Register write at the issue edge gives a result usable by the next instruction
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int u = 0; u < UNIT_CNT; u++)
        for (int i = 0; i < REG_CNT; i++)
          rf_r[u][i] <= REG_RST;
    end
    else if (mem_rd_valid_in && ld_pend_r && reg_ok(ld_dst_r))
      rf_r[ld_unit_r][ld_dst_r] <= mem_rd_data_in;
    else if (wr_en_w)
      rf_r[iss_unit_in][wr_idx_w] <= wr_val_w;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int u = 0; u < UNIT_CNT; u++)
        for (int c = 0; c < CB_CNT; c++)
        begin
          cb_base_r[u][c] <= REG_RST;
          cb_len_r[u][c]  <= REG_RST;
        end
    end
    else if (acc_w && iss_op_in == OP_CBSET)
    begin
      cb_base_r[iss_unit_in][iss_cb_in] <= cur_a_w;
      cb_len_r[iss_unit_in][iss_cb_in]  <= cur_b_w;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int u = 0; u < UNIT_CNT; u++)
        stat_r[u] <= STAT_RST;
    end
    else if (acc_w && is_alu_w)
      stat_r[iss_unit_in] <= flags_w[iss_unit_in];
  end

  // One load in flight; a second load waits rather than reorder returns
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ld_pend_r <= 1'b0;
      ld_unit_r <= 1'b0;
      ld_dst_r  <= '0;
    end
    else if (acc_w && iss_op_in == OP_LOAD)
    begin
      ld_pend_r <= 1'b1;
      ld_unit_r <= iss_unit_in;
      ld_dst_r  <= iss_dst_in;
    end
    else if (mem_rd_valid_in)
      ld_pend_r <= 1'b0;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem_req_r  <= 1'b0;
      mem_unit_r <= 1'b0;
      mem_load_r <= 1'b0;
      mem_addr_r <= '0;
      mem_size_r <= SZ_ONE;
    end
    else
    begin
      mem_req_r <= acc_w && is_mem_w;
      if (acc_w && is_mem_w)
      begin
        mem_unit_r <= iss_unit_in;
        mem_load_r <= (iss_op_in == OP_LOAD);
        mem_addr_r <= addr_w;
        mem_size_r <= iss_size_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      loop_taken_r <= 1'b0;
    else
      loop_taken_r <= acc_w && iss_op_in == OP_LOOP && cur_res_w != '0;
  end

  assign mem_req_out    = mem_req_r;
  assign mem_unit_out   = mem_unit_r;
  assign mem_load_out   = mem_load_r;
  assign mem_addr_out   = mem_addr_r;
  assign mem_size_out   = mem_size_r;
  assign loop_taken_out = loop_taken_r;

  // Checking helpers: last register write from issue
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      chk_en_r <= 1'b0;
      chk_u_r  <= 1'b0;
      chk_d_r  <= '0;
      chk_v_r  <= '0;
    end
    else
    begin
      chk_en_r <= wr_en_w && !(mem_rd_valid_in && ld_pend_r);
      chk_u_r  <= iss_unit_in;
      chk_d_r  <= wr_idx_w;
      chk_v_r  <= wr_val_w;
    end
  end

  a_result_next: assert property (@(posedge core_clk_in) disable iff (rst_in)
    chk_en_r |-> rf_r[chk_u_r][chk_d_r] == chk_v_r)
    else $error("integer result not visible in next cycle");

  a_ptr_writeback: assert property (@(posedge core_clk_in) disable iff (rst_in)
    acc_w && is_mem_w && iss_amode_in == AM_POST && reg_ok(iss_src_a_in) |=> mem_req_out && chk_en_r)
    else $error("pointer not written back with access");

  a_post_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
    acc_w && is_mem_w && iss_amode_in == AM_POST |=> mem_addr_out == $past(cur_a_w))
    else $error("post-modify address is not the old pointer");

  a_size_carry: assert property (@(posedge core_clk_in) disable iff (rst_in)
    acc_w && is_mem_w |=> mem_req_out && mem_size_out == $past(iss_size_in))
    else $error("access size not carried");

  a_circ_wrap: assert property (@(posedge core_clk_in) disable iff (rst_in)
    acc_w && is_mem_w && iss_circ_in && !iss_brev_in && iss_use_imm_in && iss_imm_in < g_unit[0].dp.len &&
    iss_unit_in == 1'b0 && cur_a_w >= g_unit[0].dp.base && cur_a_w < g_unit[0].dp.base + g_unit[0].dp.len
    |-> cur_next_w >= g_unit[0].dp.base && cur_next_w < g_unit[0].dp.base + g_unit[0].dp.len)
    else $error("circular pointer left its buffer");

  a_dep_stall: assert property (@(posedge core_clk_in) disable iff (rst_in)
    iss_valid_in && ld_pend_r && ld_unit_r == iss_unit_in && ld_dst_r == iss_src_a_in |-> iss_stall_out)
    else $error("dependent instruction issued before load data");

  a_no_false_stall: assert property (@(posedge core_clk_in) disable iff (rst_in)
    iss_valid_in && !ld_pend_r && !mem_rd_valid_in |-> !iss_stall_out)
    else $error("stall without a pending result");

  a_stat_private: assert property (@(posedge core_clk_in) disable iff (rst_in)
    acc_w && is_alu_w && iss_unit_in == 1'b0 && !mem_rd_valid_in
    |=> stat_out[STAT_W +: STAT_W] == $past(stat_out[STAT_W +: STAT_W]))
    else $error("status of other unit changed");
endmodule : iag_top

// *** dv/iag_mem_model.sv ***
// Memory side model: answers loads after a chosen delay
`timescale 1ns/1ps
module iag_mem_model #(
  parameter logic [31:0] KEY = 32'h5A5A_C3C3
) (
  input  wire logic        clk_in,       // Core clock
  input  wire logic        rst_in,       // Async reset, active high
  input  wire logic        req_in,       // Access request pulse
  input  wire logic        load_in,      // Access is a load
  input  wire logic [31:0] addr_in,      // Access address
  input  wire logic [3:0]  delay_in,     // Cycles before load return
  output logic             rd_valid_out, // Load data pulse
  output logic [31:0]      rd_data_out   // Load data
);
  logic [31:0] addr_r;
  logic [3:0]  wait_r;
  logic        busy_r;

  // Data toggles outside the return pulse so stale data never looks valid
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 32'h0000_0000;
      busy_r       <= 1'b0;
      addr_r       <= 32'h0000_0000;
      wait_r       <= 4'h0;
    end
    else
    begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= ~rd_data_out;
      if (req_in && load_in)
      begin
        busy_r <= 1'b1;
        addr_r <= addr_in;
        wait_r <= delay_in;
      end
      else if (busy_r && wait_r == 4'h0)
      begin
        rd_valid_out <= 1'b1;
        rd_data_out  <= addr_r ^ KEY;
        busy_r       <= 1'b0;
      end
      else if (busy_r)
        wait_r <= wait_r - 4'h1;
    end
  end
endmodule : iag_mem_model

// *** dv/integer_address_generator_tb.sv ***
// Testbench: drives both address units and checks accesses, registers and status
`timescale 1ns/1ps
module integer_address_generator_tb;
  import iag_pkg::*;
  localparam logic [31:0] KEY = 32'h5A5A_C3C3;
  logic              clk;
  logic              rst;
  logic              vld;
  logic              unit;
  iag_op_type        op;
  iag_amode_type     am;
  iag_size_type      sz;
  logic              circ;
  logic              brev;
  logic [CB_AW-1:0]  cb;
  logic [REG_AW-1:0] dst;
  logic [REG_AW-1:0] sa;
  logic [REG_AW-1:0] sb;
  logic              uimm;
  logic [DATA_W-1:0] imm;
  logic              stall;
  logic              req;
  logic              munit;
  logic              mload;
  logic [DATA_W-1:0] maddr;
  iag_size_type      msz;
  logic              rdv;
  logic [DATA_W-1:0] rdd;
  logic [7:0]        stat;
  logic              ltaken;
  logic [3:0]        mdelay;
  logic [36:0]       exp_q[$];
  logic [3:0]        zn[2];
  logic [31:0]       x, y, r, p, m;
  logic [31:0]       bases[8];
  iag_op_type        ops[6] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV};
  iag_amode_type     ams[3] = '{AM_IMM, AM_PRE, AM_POST};
  iag_size_type      szs[3] = '{SZ_ONE, SZ_TWO, SZ_FOUR};
  int                failures;
  int                check_count;
  int                cycles;
  int                stalls;
  int                len;

  iag_top dut (.core_clk_in(clk), .rst_in(rst), .iss_valid_in(vld), .iss_unit_in(unit), .iss_op_in(op),
    .iss_amode_in(am), .iss_size_in(sz), .iss_circ_in(circ), .iss_brev_in(brev), .iss_cb_in(cb),
    .iss_dst_in(dst), .iss_src_a_in(sa), .iss_src_b_in(sb), .iss_use_imm_in(uimm), .iss_imm_in(imm),
    .iss_stall_out(stall), .mem_req_out(req), .mem_unit_out(munit), .mem_load_out(mload),
    .mem_addr_out(maddr), .mem_size_out(msz), .mem_rd_valid_in(rdv), .mem_rd_data_in(rdd),
    .stat_out(stat), .loop_taken_out(ltaken));

  iag_mem_model #(.KEY(KEY)) mem (.clk_in(clk), .rst_in(rst), .req_in(req), .load_in(mload),
    .addr_in(maddr), .delay_in(mdelay), .rd_valid_out(rdv), .rd_data_out(rdd));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rev(input logic [31:0] v);
    for (int i = 0; i < 32; i++)
      rev[i] = v[31-i];
  endfunction : rev

  function automatic logic [31:0] alu(input iag_op_type o, input logic [31:0] a, input logic [31:0] b);
    case (o)
      OP_ADD:  return a + b;
      OP_SUB:  return a - b;
      OP_AND:  return a & b;
      OP_OR:   return a | b;
      OP_MOV:  return b;
      default: return a ^ b;
    endcase
  endfunction : alu

  // Status as {V, C, N, Z}; C is the carry out, or the borrow of a subtract
  function automatic logic [3:0] flg(input iag_op_type o, input logic [31:0] a, input logic [31:0] b);
    logic [32:0] w;
    logic        v;
    w = {1'b0, alu(o, a, b)};
    v = 1'b0;
    if (o == OP_ADD)
    begin
      w = {1'b0, a} + {1'b0, b};
      v = (a[31] == b[31]) && (w[31] != a[31]);
    end
    else if (o == OP_SUB)
    begin
      w = {1'b0, a} - {1'b0, b};
      v = (a[31] != b[31]) && (w[31] != a[31]);
    end
    return {v, w[32], w[31], w[31:0] == 32'h0};
  endfunction : flg

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expv);
    check_count++;
    if (seen !== expv)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // Held until a falling edge shows no stall; returns at the accepting edge
  task automatic issue(input logic u, input iag_op_type o, input logic [4:0] d, input logic [4:0] a,
                       input logic [31:0] im, input logic ui = 1'b1, input logic [4:0] b = 5'd0,
                       input iag_amode_type md = AM_IMM, input iag_size_type s = SZ_ONE,
                       input logic ci = 1'b0, input logic br = 1'b0, input logic [1:0] c = 2'h0);
    @(negedge clk);
    vld  = 1'b1;
    unit = u;
    op   = o;
    dst  = d;
    sa   = a;
    sb   = b;
    uimm = ui;
    imm  = im;
    am   = md;
    sz   = s;
    circ = ci;
    brev = br;
    cb   = c;
    #1;
    while (stall === 1'b1)
    begin
      stalls++;
      @(negedge clk);
      #1;
    end
    @(posedge clk);
  endtask : issue

  task automatic set(input logic u, input logic [4:0] rg, input logic [31:0] v);
    issue(u, OP_ADD, rg, 5'd31, v);
    zn[u] = flg(OP_ADD, 32'h0, v);
  endtask : set

  // Store with zero post-modify exposes the pointer on the address lines
  task automatic peek(input logic u, input logic [4:0] rg, input logic [31:0] v);
    exp_q.push_back({u, 1'b0, SZ_ONE, v});
    issue(u, OP_LDST, 5'd31, rg, 32'h0, 1'b1, 5'd0, AM_POST);
  endtask : peek

  always @(negedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      failures++;
      close_out();
    end
    if (req === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected access", 64'h1, 64'h0);
      else
        check("access", {munit, mload, msz, maddr}, exp_q.pop_front());
    end
  end

  initial
  begin
    {failures, check_count, cycles, stalls} = '0;
    {vld, unit, circ, brev, cb, dst, sa, sb, uimm, imm, mdelay} = '0;
    op  = OP_ADD;
    am  = AM_IMM;
    sz  = SZ_ONE;
    zn  = '{4'h0, 4'h0};
    rst = 1'b1;
    void'($urandom(49091));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check("reset status", stat, 8'h00);
    check("reset size", msz, SZ_ONE);
    for (int u = 0; u < 2; u++)
      for (int k = 0; k < 31; k++)
        set(u[0], k[4:0], 32'h1000_0000 * (u + 1) + k);
    for (int u = 0; u < 2; u++)
      for (int k = 0; k < 32; k++)
        peek(u[0], k[4:0], (k == 31) ? 32'h0 : 32'h1000_0000 * (u + 1) + k);
    for (int i = 0; i < 12; i++)
    begin
      x = $urandom();
      y = (i == 7) ? x : $urandom();
      set(i[0], 5'd1, x);
      set(i[0], 5'd3, y);
      issue(i[0], ops[i % 6], 5'd2, 5'd1, y, i[1], 5'd3);
      r = alu(ops[i % 6], x, y);
      zn[i[0]] = flg(ops[i % 6], x, y);
      #1;
      check("status", stat, {zn[1], zn[0]});
      peek(i[0], 5'd2, r);
    end
    for (int i = 0; i < 9; i++)
    begin
      p = $urandom();
      m = $urandom_range(0, 255);
      set(1'b1, 5'd5, p);
      exp_q.push_back({1'b1, 1'b0, szs[i / 3], (i % 3 == 0) ? m : (i % 3 == 1) ? p + m : p});
      issue(1'b1, OP_LDST, 5'd31, 5'd5, m, 1'b1, 5'd0, ams[i % 3], szs[i / 3]);
      peek(1'b1, 5'd5, (i % 3 == 0) ? p : p + m);
    end
    for (int k = 0; k < 8; k++)
    begin
      bases[k] = ($urandom() & 32'h00FF_FFFF) | 32'h0000_0100;
      set(k[2], 5'd6, bases[k]);
      issue(k[2], OP_CBSET, 5'd31, 5'd6, 32'(5 + 3 * (k % 4)), 1'b1, 5'd0, AM_IMM, SZ_ONE, 1'b0, 1'b0, k[1:0]);
    end
    // All eight buffers live at once, so a shared set would corrupt them
    for (int k = 0; k < 8; k++)
    begin
      len = 5 + 3 * (k % 4);
      p = bases[k] + len - 2;
      set(k[2], 5'd7, p);
      exp_q.push_back({k[2], 1'b0, SZ_ONE, p});
      issue(k[2], OP_LDST, 5'd31, 5'd7, 32'h3, 1'b1, 5'd0, AM_POST, SZ_ONE, 1'b1, 1'b0, k[1:0]);
      exp_q.push_back({k[2], 1'b0, SZ_ONE, bases[k] + 1});
      issue(k[2], OP_LDST, 5'd31, 5'd7, 32'hFFFF_FFFD, 1'b1, 5'd0, AM_POST, SZ_ONE, 1'b1, 1'b0, k[1:0]);
      peek(k[2], 5'd7, p);
    end
    for (int i = 0; i < 4; i++)
    begin
      p = $urandom();
      m = $urandom();
      set(1'b0, 5'd8, p);
      exp_q.push_back({1'b0, 1'b0, SZ_FOUR, p});
      issue(1'b0, OP_LDST, 5'd31, 5'd8, m, 1'b1, 5'd0, AM_POST, SZ_FOUR, 1'b1, 1'b1);
      peek(1'b0, 5'd8, rev(rev(p) + rev(m)));
    end
    set(1'b1, 5'd9, 32'h2);
    issue(1'b1, OP_LOOP, 5'd9, 5'd9, 32'h0);
    #1;
    check("loop taken", ltaken, 1'b1);
    issue(1'b1, OP_LOOP, 5'd9, 5'd9, 32'h0);
    #1;
    zn[1] = flg(OP_SUB, 32'h1, 32'h1);
    check("loop end", {ltaken, stat[7:4]}, {1'b0, zn[1]});
    peek(1'b1, 5'd9, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      mdelay = 4'(6 * i);
      p = $urandom() & 32'h00FF_FFF0;
      set(1'b0, 5'd10, p);
      exp_q.push_back({1'b0, 1'b1, SZ_TWO, p});
      issue(1'b0, OP_LOAD, 5'd11, 5'd10, 32'h2, 1'b1, 5'd0, AM_POST, SZ_TWO);
      stalls = 0;
      issue(1'b0, OP_ADD, 5'd12, 5'd11, 32'h1);
      r = (p ^ KEY) + 32'h1;
      zn[0] = flg(OP_ADD, p ^ KEY, 32'h1);
      check("dependency stall", stalls > 0, 1'b1);
      #1;
      check("load status", stat[3:0], zn[0]);
      peek(1'b0, 5'd12, r);
      peek(1'b0, 5'd10, p + 32'h2);
    end
    @(negedge clk);
    vld = 1'b0;
    repeat (4) @(negedge clk);
    check("pending accesses", exp_q.size(), 0);
    close_out();
  end
endmodule : integer_address_generator_tb
